// ===== rtl/sapr_pkg.sv
// Shared constants and types for the stabilization auxiliary port readout
package sapr_pkg;
    // Register addresses on the auxiliary port
    localparam logic [6:0] ADDR_STATUS  = 7'h1E;
    localparam logic [6:0] ADDR_CTRL1   = 7'h70;
    localparam logic [6:0] ADDR_ACFG    = 7'h72;
    localparam logic [6:0] ADDR_GYRO_LO = 7'h22;
    localparam logic [6:0] ADDR_GYRO_HI = 7'h27;
    localparam logic [6:0] ADDR_ACC_LO  = 7'h28;
    localparam logic [6:0] ADDR_ACC_HI  = 7'h2D;
    // Field positions in stab_accel_config
    localparam int FS_MSB   = 7;
    localparam int FS_LSB   = 6;
    localparam int LPF_MSB  = 5;
    localparam int LPF_LSB  = 3;
    localparam int SELF_MSB = 2;
    localparam int SELF_LSB = 1;
    localparam int CLAMP_DIS = 0;
    // Field positions in stab_control_first
    localparam int GYRO_EN  = 0;
    localparam int ACC_EN   = 4;
    localparam int WIRE3    = 5;
    // Field positions in aux_port_status
    localparam int SETTLE_B = 2;
    localparam int GDA_B    = 1;
    localparam int NEW_ACCEL_SAMPLE_FLAG_B   = 0;
    // Reset values and masks
    localparam logic [7:0] CTRL1_RST  = 8'h00;
    localparam logic [7:0] CTRL1_MASK = 8'h7F;
    localparam logic [7:0] ACFG_RST   = 8'h00;
    // Sample codes
    localparam logic [15:0] CLAMP_VALUE  = 16'h8000;
    localparam logic [15:0] NORMAL_FLOOR = 16'h8001;
    // Serial frame layout
    localparam int SPI_RW_BIT = 7;
    // Timing
    localparam int CLK_HZ       = 20_000_000;
    localparam int BOOT_MS      = 10;
    localparam int TURNON_MS    = 70;
    localparam int BOOT_CYC     = BOOT_MS * (CLK_HZ / 1000);
    localparam int TURNON_CYC   = TURNON_MS * (CLK_HZ / 1000);
    localparam int GYRO_FIRST_LOWPASS_SAMPLES = 27;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } sapr_req_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } sapr_axes_t;

    typedef enum logic [3:0] {
        SET_OFF    = 4'b0001,
        SET_TURNON = 4'b0010,
        SET_FILTER = 4'b0100,
        SET_READY  = 4'b1000
    } sapr_settle_t;
endpackage

// ===== rtl/sapr_aux_spi.sv
// Auxiliary serial port slave, oversampled by the system clock
`timescale 1ns/1ps
module sapr_aux_spi (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             sclk,
    input  wire logic             csN,
    input  wire logic             sdi,
    input  wire logic             threeWire,
    input  wire logic [7:0]       rdData,
    output sapr_pkg::sapr_req_t   req,
    output logic                  sdo,
    output logic                  sdoEn
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] sclkS_q;
    logic [2:0] csS_q;
    logic [1:0] sdiS_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclkS_q <= 3'h7;
            csS_q   <= 3'h7;
            sdiS_q  <= 2'h0;
        end else begin
            sclkS_q <= {sclkS_q[1:0], sclk};
            csS_q   <= {csS_q[1:0], csN};
            sdiS_q  <= {sdiS_q[0], sdi};
        end
    end

    logic rise;
    logic fall;
    logic csAct;
    assign rise  = sclkS_q[1] & ~sclkS_q[2];
    assign fall  = ~sclkS_q[1] & sclkS_q[2];
    assign csAct = ~csS_q[1];

    ////////////////////////////////////////////////////////////////////
    // Frame shifter
    logic [2:0]          bitCnt_q, bitCnt_d;
    logic                first_q, first_d;
    logic                rw_q, rw_d;
    logic [6:0]          addr_q, addr_d;
    logic [7:0]          shIn_q, shIn_d;
    logic [7:0]          shOut_q, shOut_d;
    sapr_pkg::sapr_req_t req_q, req_d;
    logic                sdo_q, sdo_d;
    logic                sdoEn_q, sdoEn_d;

    always_comb begin
        bitCnt_d = bitCnt_q;
        first_d  = first_q;
        rw_d     = rw_q;
        addr_d   = addr_q;
        shIn_d   = shIn_q;
        shOut_d  = shOut_q;
        sdo_d    = sdo_q;
        req_d    = '0;
        if (req_q.rd) begin
            shOut_d = rdData;
        end
        if (!csAct) begin
            first_d  = 1'b1;
            bitCnt_d = 3'h0;
        end else if (rise) begin
            shIn_d   = {shIn_q[6:0], sdiS_q[1]};
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
                if (first_q) begin
                    first_d    = 1'b0;
                    rw_d       = shIn_d[sapr_pkg::SPI_RW_BIT];
                    addr_d     = shIn_d[6:0];
                    req_d.rd   = shIn_d[sapr_pkg::SPI_RW_BIT];
                    req_d.addr = shIn_d[6:0];
                end else if (rw_q) begin
                    addr_d     = addr_q + 7'h01;
                    req_d.rd   = 1'b1;
                    req_d.addr = addr_q + 7'h01;
                end else begin
                    addr_d      = addr_q + 7'h01;
                    req_d.wr    = 1'b1;
                    req_d.addr  = addr_q;
                    req_d.wdata = shIn_d;
                end
            end
        end else if (fall && rw_q && !first_q) begin
            sdo_d   = shOut_q[7];
            shOut_d = {shOut_q[6:0], 1'b0};
        end
        sdoEn_d = csAct & (threeWire ? (rw_d & ~first_d) : 1'b1);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_q <= 3'h0;
            first_q  <= 1'b1;
            rw_q     <= 1'b0;
            addr_q   <= 7'h00;
            shIn_q   <= 8'h00;
            shOut_q  <= 8'h00;
            req_q    <= '0;
            sdo_q    <= 1'b0;
            sdoEn_q  <= 1'b0;
        end else begin
            bitCnt_q <= bitCnt_d;
            first_q  <= first_d;
            rw_q     <= rw_d;
            addr_q   <= addr_d;
            shIn_q   <= shIn_d;
            shOut_q  <= shOut_d;
            req_q    <= req_d;
            sdo_q    <= sdo_d;
            sdoEn_q  <= sdoEn_d;
        end
    end

    assign req   = req_q;
    assign sdo   = sdo_q;
    assign sdoEn = sdoEn_q;
endmodule

// ===== rtl/sapr_readout.sv
// Stabilization readout: registers, sample path, settle tracking
`timescale 1ns/1ps
module sapr_readout #(
    parameter int BootCycles    = sapr_pkg::BOOT_CYC,
    parameter int TurnonCycles  = sapr_pkg::TURNON_CYC,
    parameter int FilterSamples = sapr_pkg::GYRO_FIRST_LOWPASS_SAMPLES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 auxSclk,
    input  wire logic                 auxCsN,
    input  wire logic                 auxSdi,
    input  wire logic                 gyroValid,
    input  wire sapr_pkg::sapr_axes_t gyroIn,
    input  wire logic                 accelValid,
    input  wire sapr_pkg::sapr_axes_t accelIn,
    input  wire logic                 primarySideGyroSelftest,
    input  wire logic                 primarySideAccelSelftest,
    input  wire logic                 primarySideGyroOn,
    output logic                      auxSdo,
    output logic                      auxSdoEn,
    output logic [1:0]                stabAccelFullScale,
    output logic [2:0]                stabAccelLowpassSelect,
    output logic [1:0]                stabGyroSelftestSelect,
    output logic                      gyroChainOn,
    output logic                      accelChainOn,
    output logic                      threeWireSelect,
    output logic                      bootDone,
    output logic                      gyroSettling
);
    if (BootCycles < 1 || TurnonCycles < 1 || FilterSamples < 1 ||
        BootCycles >= 2**30 || TurnonCycles >= 2**30 ||
        FilterSamples >= 2**30) begin : g_chk
        $error("sapr_readout: timing parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [15:0] shapeSample(logic [15:0] v,
                                                logic st, logic dis);
        if (st && !dis) begin
            shapeSample = sapr_pkg::CLAMP_VALUE;
        end else if (v == sapr_pkg::CLAMP_VALUE) begin
            shapeSample = sapr_pkg::NORMAL_FLOOR;
        end else begin
            shapeSample = v;
        end
    endfunction

    function automatic sapr_pkg::sapr_axes_t shapeAxes(
        sapr_pkg::sapr_axes_t a, logic st, logic dis);
        shapeAxes.x = shapeSample(a.x, st, dis);
        shapeAxes.y = shapeSample(a.y, st, dis);
        shapeAxes.z = shapeSample(a.z, st, dis);
    endfunction

    function automatic logic [7:0] pickByte(sapr_pkg::sapr_axes_t a,
                                            logic [2:0] idx);
        case (idx)
            3'h0:    pickByte = a.x[7:0];
            3'h1:    pickByte = a.x[15:8];
            3'h2:    pickByte = a.y[7:0];
            3'h3:    pickByte = a.y[15:8];
            3'h4:    pickByte = a.z[7:0];
            default: pickByte = a.z[15:8];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Serial port
    sapr_pkg::sapr_req_t req;
    logic [7:0]          rdData;

    sapr_aux_spi u_spi (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .sclk      (auxSclk),
        .csN       (auxCsN),
        .sdi       (auxSdi),
        .threeWire (threeWireSelect),
        .rdData    (rdData),
        .req       (req),
        .sdo       (auxSdo),
        .sdoEn     (auxSdoEn)
    );

    ////////////////////////////////////////////////////////////////////
    // Registers and sample store
    logic [30:0]          bootCnt_q, bootCnt_d;
    logic                 bootDone_q, bootDone_d;
    logic [7:0]           ctrl1_q, ctrl1_d;
    logic [7:0]           acfg_q, acfg_d;
    logic                 gyroOn_q, gyroOn_d;
    logic                 accelOn_q, accelOn_d;
    sapr_pkg::sapr_axes_t gyro_q, gyro_d;
    sapr_pkg::sapr_axes_t accel_q, accel_d;
    logic                 gda_q, gda_d;
    logic                 new_accel_sample_flag_q, new_accel_sample_flag_d;
    logic                 anySelftest;
    logic                 gyroLoad;
    logic                 accelLoad;
    logic                 gyroHiRead;
    logic                 accelHiRead;
    logic                 busWr;

    assign anySelftest = (acfg_q[sapr_pkg::SELF_MSB:sapr_pkg::SELF_LSB]
                          != 2'h0) | primarySideGyroSelftest
                         | primarySideAccelSelftest;
    assign gyroLoad    = gyroValid & gyroOn_q;
    assign accelLoad   = accelValid & accelOn_q;
    assign busWr       = req.wr & bootDone_q;
    assign gyroHiRead  = req.rd & req.addr[0] &
                         (req.addr >= sapr_pkg::ADDR_GYRO_LO) &
                         (req.addr <= sapr_pkg::ADDR_GYRO_HI);
    assign accelHiRead = req.rd & req.addr[0] &
                         (req.addr >= sapr_pkg::ADDR_ACC_LO) &
                         (req.addr <= sapr_pkg::ADDR_ACC_HI);

    always_comb begin
        bootCnt_d  = bootCnt_q;
        bootDone_d = bootDone_q;
        ctrl1_d    = ctrl1_q;
        acfg_d     = acfg_q;
        gyro_d     = gyro_q;
        accel_d    = accel_q;
        if (!bootDone_q) begin
            bootCnt_d  = bootCnt_q + 31'h1;
            bootDone_d = (bootCnt_q == 31'(BootCycles - 1));
        end
        if (busWr && req.addr == sapr_pkg::ADDR_CTRL1) begin
            ctrl1_d = req.wdata & sapr_pkg::CTRL1_MASK;
        end
        if (busWr && req.addr == sapr_pkg::ADDR_ACFG) begin
            acfg_d = req.wdata;
        end
        gyroOn_d  = bootDone_q & ctrl1_d[sapr_pkg::GYRO_EN];
        accelOn_d = gyroOn_d & ctrl1_d[sapr_pkg::ACC_EN];
        if (gyroLoad) begin
            gyro_d = shapeAxes(gyroIn, anySelftest,
                               acfg_q[sapr_pkg::CLAMP_DIS]);
        end
        if (accelLoad) begin
            accel_d = shapeAxes(accelIn, anySelftest,
                                acfg_q[sapr_pkg::CLAMP_DIS]);
        end
        gda_d  = gyroLoad | (gda_q & ~gyroHiRead);
        new_accel_sample_flag_d = accelLoad | (new_accel_sample_flag_q & ~accelHiRead);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bootCnt_q  <= 31'h0;
            bootDone_q <= 1'b0;
            ctrl1_q    <= sapr_pkg::CTRL1_RST;
            acfg_q     <= sapr_pkg::ACFG_RST;
            gyroOn_q   <= 1'b0;
            accelOn_q  <= 1'b0;
            gyro_q     <= '0;
            accel_q    <= '0;
            gda_q      <= 1'b0;
            new_accel_sample_flag_q     <= 1'b0;
        end else begin
            bootCnt_q  <= bootCnt_d;
            bootDone_q <= bootDone_d;
            ctrl1_q    <= ctrl1_d;
            acfg_q     <= acfg_d;
            gyroOn_q   <= gyroOn_d;
            accelOn_q  <= accelOn_d;
            gyro_q     <= gyro_d;
            accel_q    <= accel_d;
            gda_q      <= gda_d;
            new_accel_sample_flag_q     <= new_accel_sample_flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Gyro settle tracking
    sapr_pkg::sapr_settle_t state_q, state_d;
    logic [30:0]            cnt_q, cnt_d;
    logic                   settle_q, settle_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            sapr_pkg::SET_OFF: begin
                cnt_d = 31'h0;
                if (gyroOn_q) begin
                    state_d = primarySideGyroOn ? sapr_pkg::SET_FILTER
                                                : sapr_pkg::SET_TURNON;
                end
            end
            sapr_pkg::SET_TURNON: begin
                cnt_d = cnt_q + 31'h1;
                if (cnt_q == 31'(TurnonCycles - 1)) begin
                    state_d = sapr_pkg::SET_FILTER;
                    cnt_d   = 31'h0;
                end
            end
            sapr_pkg::SET_FILTER: begin
                if (gyroValid) begin
                    cnt_d = cnt_q + 31'h1;
                end
                if (gyroValid && cnt_q == 31'(FilterSamples - 1)) begin
                    state_d = sapr_pkg::SET_READY;
                end
            end
            sapr_pkg::SET_READY: begin
                cnt_d = cnt_q;
            end
            default: begin
                state_d = sapr_pkg::SET_OFF;
            end
        endcase
        if (!gyroOn_q) begin
            state_d = sapr_pkg::SET_OFF;
        end
        settle_d = (state_d == sapr_pkg::SET_TURNON) |
                   (state_d == sapr_pkg::SET_FILTER);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= sapr_pkg::SET_OFF;
            cnt_q    <= 31'h0;
            settle_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            settle_q <= settle_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rdData = 8'h00;
        if (!bootDone_q) begin
            rdData = 8'h00;
        end else if (req.addr == sapr_pkg::ADDR_STATUS) begin
            rdData[sapr_pkg::SETTLE_B] = settle_q;
            rdData[sapr_pkg::GDA_B]    = gda_q;
            rdData[sapr_pkg::NEW_ACCEL_SAMPLE_FLAG_B]   = new_accel_sample_flag_q;
        end else if (req.addr == sapr_pkg::ADDR_CTRL1) begin
            rdData = ctrl1_q;
        end else if (req.addr == sapr_pkg::ADDR_ACFG) begin
            rdData = acfg_q;
        end else if (req.addr >= sapr_pkg::ADDR_GYRO_LO &&
                     req.addr <= sapr_pkg::ADDR_GYRO_HI) begin
            rdData = pickByte(gyro_q,
                              3'(req.addr - sapr_pkg::ADDR_GYRO_LO));
        end else if (req.addr >= sapr_pkg::ADDR_ACC_LO &&
                     req.addr <= sapr_pkg::ADDR_ACC_HI) begin
            rdData = pickByte(accel_q,
                              3'(req.addr - sapr_pkg::ADDR_ACC_LO));
        end
    end

    assign stabAccelFullScale =
        acfg_q[sapr_pkg::FS_MSB:sapr_pkg::FS_LSB];
    assign stabAccelLowpassSelect =
        acfg_q[sapr_pkg::LPF_MSB:sapr_pkg::LPF_LSB];
    assign stabGyroSelftestSelect =
        acfg_q[sapr_pkg::SELF_MSB:sapr_pkg::SELF_LSB];
    assign threeWireSelect = ctrl1_q[sapr_pkg::WIRE3];
    assign gyroChainOn     = gyroOn_q;
    assign accelChainOn    = accelOn_q;
    assign bootDone        = bootDone_q;
    assign gyroSettling    = settle_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_cfg_fs;
        busWr && req.addr == sapr_pkg::ADDR_ACFG |=>
            stabAccelFullScale == $past(req.wdata[7:6]);
    endproperty
    a_cfg_fs: assert property (p_cfg_fs)
        else $error("full scale not taken from write");

    property p_cfg_lpf;
        busWr && req.addr == sapr_pkg::ADDR_ACFG |=>
            stabAccelLowpassSelect == $past(req.wdata[5:3]);
    endproperty
    a_cfg_lpf: assert property (p_cfg_lpf)
        else $error("low-pass select not taken from write");

    property p_cfg_self;
        busWr && req.addr == sapr_pkg::ADDR_ACFG |=>
            stabGyroSelftestSelect == $past(req.wdata[2:1]);
    endproperty
    a_cfg_self: assert property (p_cfg_self)
        else $error("gyro self-test select not taken from write");

    property p_pass;
        gyroLoad && acfg_q[0] && gyroIn.x != 16'h8000 |=>
            gyro_q.x == $past(gyroIn.x);
    endproperty
    a_pass: assert property (p_pass)
        else $error("unclamped sample altered");

    property p_clamp;
        gyroLoad && anySelftest && !acfg_q[0] |=>
            gyro_q.x == 16'h8000 && gyro_q.z == 16'h8000;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("self-test sample not clamped");

    property p_normal;
        accelLoad && !anySelftest |=> accel_q.y != 16'h8000;
    endproperty
    a_normal: assert property (p_normal)
        else $error("normal sample reached clamp code");

    sequence s_gyro_start;
        !gyroOn_q ##1 gyroOn_q && !primarySideGyroOn;
    endsequence
    sequence s_settling;
        gyroSettling [*8];
    endsequence
    property p_settle;
        s_gyro_start |=> s_settling;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settle flag missing after gyro start");

    property p_gda;
        gyroLoad |=> gda_q ##1 (gda_q || $past(gyroHiRead));
    endproperty
    a_gda: assert property (p_gda)
        else $error("new gyro flag not held");

    property p_gda_clr;
        gyroHiRead && !gyroLoad |=> !gda_q;
    endproperty
    a_gda_clr: assert property (p_gda_clr)
        else $error("new gyro flag not cleared");

    property p_new_accel_sample_flag;
        accelHiRead && !accelLoad |=> !new_accel_sample_flag_q;
    endproperty
    a_new_accel_sample_flag: assert property (p_new_accel_sample_flag)
        else $error("new accel flag not cleared");

    property p_boot;
        !bootDone |-> !gyroChainOn && !accelChainOn;
    endproperty
    a_boot: assert property (p_boot)
        else $error("chain on before boot done");

    property p_chain;
        accelChainOn |-> gyroChainOn;
    endproperty
    a_chain: assert property (p_chain)
        else $error("accel chain on without gyro chain");

    property p_status;
        req.rd && req.addr == sapr_pkg::ADDR_STATUS |-> rdData[7:3] == 5'h00;
    endproperty
    a_status: assert property (p_status)
        else $error("status upper bits not zero");
endmodule

// ===== tb/sapr_host_model.sv
// Host controller model driving the auxiliary serial port
`timescale 1ns/1ps
module sapr_host_model (
    input  wire logic       clk_sys,
    input  wire logic       sdo,
    output logic            sclk,
    output logic            csN,
    output logic            sdi,
    output logic            rxValid,
    output logic [7:0]      rxByte
);
    initial begin
        sclk = 1'b1;
        csN = 1'b1;
        sdi = 1'b0;
        rxValid = 1'b0;
        rxByte = 8'h00;
    end
    // One byte, MSB first; sampled late in the high phase
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_sys);
            sclk <= 1'b0;
            sdi <= tx[i];
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b1;
            repeat (3) @(posedge clk_sys);
            rx[i] = sdo;
        end
    endtask
    // Frame: command byte then n data bytes; clock idles high between
    task automatic frame(input logic rd, input logic [6:0] a,
                         input logic [7:0] wd, input int n);
        logic [7:0] r;
        @(posedge clk_sys);
        csN <= 1'b0;
        shift({rd, a}, r);
        repeat (n) begin
            shift(wd, r);
            if (rd) begin
                rxByte <= r;
                rxValid <= 1'b1;
                @(posedge clk_sys);
                rxValid <= 1'b0;
            end
        end
        repeat (4) @(posedge clk_sys);
        csN <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

// ===== tb/stabilizer_aux_port_readout_test.sv
// Self-checking bench for the stabilization readout block
`timescale 1ns/1ps
module stabilizer_aux_port_readout_test;
    logic                 clk_sys = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 gyroValid;
    logic                 accelValid;
    logic                 pGyroSt;
    logic                 pAccSt;
    logic                 pGyroOn;
    sapr_pkg::sapr_axes_t gyroIn;
    sapr_pkg::sapr_axes_t accelIn;
    sapr_pkg::sapr_axes_t v;
    logic                 sclk, csN, sdi, sdo, sdoEn, rxValid;
    logic [7:0]           rxByte, d;
    logic [1:0]           fs, st;
    logic [2:0]           lpf;
    logic                 gOn, aOn, w3, boot, settle;
    logic [7:0]           expQ[$];
    int                   seed = 88046;
    int                   bad_count = 0;
    int                   tests_run = 0;
    always #25 clk_sys = ~clk_sys;
    sapr_readout #(.BootCycles(50), .TurnonCycles(100),
        .FilterSamples(4)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .auxSclk(sclk), .auxCsN(csN),
        .auxSdi(sdi), .gyroValid(gyroValid), .gyroIn(gyroIn),
        .accelValid(accelValid), .accelIn(accelIn),
        .primarySideGyroSelftest(pGyroSt), .primarySideAccelSelftest(pAccSt),
        .primarySideGyroOn(pGyroOn), .auxSdo(sdo), .auxSdoEn(sdoEn),
        .stabAccelFullScale(fs), .stabAccelLowpassSelect(lpf),
        .stabGyroSelftestSelect(st), .gyroChainOn(gOn), .accelChainOn(aOn),
        .threeWireSelect(w3), .bootDone(boot), .gyroSettling(settle));
    sapr_host_model HOST (.clk_sys(clk_sys), .sdo(sdo), .sclk(sclk),
        .csN(csN), .sdi(sdi), .rxValid(rxValid), .rxByte(rxByte));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    always @(posedge clk_sys) begin
        if (rxValid === 1'b1) begin
            check(rxByte, expQ.pop_front());
            check(sdoEn, 1'b1);
        end
    end
    task automatic rd(input logic [6:0] a, input int n);
        HOST.frame(1'b1, a, 8'h00, n);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] wd);
        HOST.frame(1'b0, a, wd, 1);
    endtask
    task automatic exp6(input sapr_pkg::sapr_axes_t e);
        for (int i = 2; i >= 0; i--) begin
            expQ.push_back(e[16*i+:8]);
            expQ.push_back(e[16*i+8+:8]);
        end
    endtask
    task automatic pulse(input logic acc);
        v = {16'($random(seed)), 16'($random(seed)), 16'h8000};
        @(posedge clk_sys);
        gyroIn <= v;
        accelIn <= v;
        gyroValid <= !acc;
        accelValid <= acc;
        @(posedge clk_sys);
        gyroValid <= 1'b0;
        accelValid <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {gyroValid, accelValid, pGyroSt, pAccSt, pGyroOn} <= 5'h00;
        gyroIn <= '0;
        accelIn <= '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check(boot, 1'b0);
        repeat (60) @(posedge clk_sys);
        check(boot, 1'b1);
        for (int i = 0; i < 8; i++) begin
            d = {2'($random(seed)), 3'(i), 3'($random(seed))};
            wr(sapr_pkg::ADDR_ACFG, d);
            check(fs, d[7:6]);
            check(lpf, d[5:3]);
            check(st, d[2:1]);
            expQ.push_back(d);
            rd(sapr_pkg::ADDR_ACFG, 1);
        end
        wr(sapr_pkg::ADDR_ACFG, 8'h00);
        $display("config test done");
        wr(sapr_pkg::ADDR_CTRL1, 8'h31);
        check({w3, aOn, gOn, settle}, 4'hF);
        wr(sapr_pkg::ADDR_CTRL1, 8'hB1);
        expQ.push_back(8'h31);
        rd(sapr_pkg::ADDR_CTRL1, 1);
        repeat (100) @(posedge clk_sys);
        check(settle, 1'b1);
        repeat (4) pulse(1'b0);
        repeat (3) @(posedge clk_sys);
        check(settle, 1'b0);
        expQ.push_back(8'h02);
        rd(sapr_pkg::ADDR_STATUS, 1);
        exp6({v.x, v.y, 16'h8001});
        rd(sapr_pkg::ADDR_GYRO_LO, 6);
        pulse(1'b1);
        expQ.push_back(8'h01);
        rd(sapr_pkg::ADDR_STATUS, 1);
        exp6({v.x, v.y, 16'h8001});
        rd(sapr_pkg::ADDR_ACC_LO, 6);
        wr(sapr_pkg::ADDR_STATUS, 8'hFF);
        expQ.push_back(8'h00);
        rd(sapr_pkg::ADDR_STATUS, 1);
        $display("sample test done");
        wr(sapr_pkg::ADDR_ACFG, 8'h02);
        pulse(1'b0);
        exp6({3{16'h8000}});
        rd(sapr_pkg::ADDR_GYRO_LO, 6);
        wr(sapr_pkg::ADDR_ACFG, 8'h01);
        pGyroSt <= 1'b1;
        pAccSt <= 1'b1;
        pulse(1'b0);
        exp6({v.x, v.y, 16'h8001});
        rd(sapr_pkg::ADDR_GYRO_LO, 6);
        pulse(1'b1);
        exp6({v.x, v.y, 16'h8001});
        rd(sapr_pkg::ADDR_ACC_LO, 6);
        wr(sapr_pkg::ADDR_ACFG, 8'h00);
        pulse(1'b1);
        exp6({3{16'h8000}});
        rd(sapr_pkg::ADDR_ACC_LO, 6);
        pGyroSt <= 1'b0;
        pAccSt <= 1'b0;
        wr(sapr_pkg::ADDR_CTRL1, 8'h00);
        check({aOn, gOn, settle}, 3'h0);
        pGyroOn <= 1'b1;
        wr(sapr_pkg::ADDR_CTRL1, 8'h21);
        check(settle, 1'b1);
        repeat (4) pulse(1'b0);
        repeat (3) @(posedge clk_sys);
        check(settle, 1'b0);
        exp6({v.x, v.y, 16'h8001});
        rd(sapr_pkg::ADDR_GYRO_LO, 6);
        $display("self-test test done");
        give_verdict();
    end
endmodule
